//--- bench/tdtc_host_model.sv
// Purpose: host side of the register port of the jolt and tap block
// Assumes: one strobe per transfer, read data taken after the edge that accepts it
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module tdtc_host_model
(
   input  wire logic       sys_clk,
   output logic            regWrite,
   output logic            regRead,
   output logic [7:0]      regAddr,
   output logic [7:0]      regWdata,
   input  wire logic [7:0] regRdata
);
   initial
   begin
      regWrite = 1'b0;
      regRead  = 1'b0;
      regAddr  = 8'hff;
      regWdata = 8'hff;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      regAddr  <= ~a;
      regWdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdata;
   endtask
endmodule // tdtc_host_model

//--- bench/test_transient_debounce_tap_config.sv
// Purpose: self-checking bench for the jolt debounce and tap configuration block
// Assumes: base step shortened to 4 cycles, every step a multiple of it
// Notes:   step lengths are measured between transient event edges
`timescale 1ns/1ps
module test_transient_debounce_tap_config;
   localparam int unsigned BASE = 4;
   typedef struct packed {
      logic [2:0] rate;
      logic [1:0] mode;
      logic [7:0] mult;
   } tdtc_row_t;
   localparam tdtc_row_t ROWS [16] = '{
      '{3'h0, 2'h0, 8'h01}, '{3'h0, 2'h2, 8'h01}, '{3'h1, 2'h3, 8'h02}, '{3'h2, 2'h1, 8'h04},
      '{3'h2, 2'h2, 8'h02}, '{3'h3, 2'h0, 8'h08}, '{3'h3, 2'h2, 8'h02}, '{3'h4, 2'h3, 8'h10},
      '{3'h4, 2'h2, 8'h02}, '{3'h5, 2'h0, 8'h10}, '{3'h5, 2'h1, 8'h40}, '{3'h5, 2'h3, 8'h40},
      '{3'h6, 2'h3, 8'h80}, '{3'h7, 2'h2, 8'h02}, '{3'h7, 2'h1, 8'h40}, '{3'h6, 2'h0, 8'h10}};

   logic                    sys_clk;
   logic                    nrst;
   logic                    regWrite;
   logic                    regRead;
   logic [7:0]              regAddr;
   logic [7:0]              regWdata;
   logic [7:0]              regRdata;
   tdtc_pkg::tdtc_rate_t    outputSampleRate;
   tdtc_pkg::tdtc_mode_t    sampleMode;
   logic                    joltExceed;
   logic                    debounceCounterMode;
   tdtc_pkg::tdtc_tap_hit_t tapHit;
   logic                    latencyOpen;
   logic                    pulseStart;
   logic                    pulseEnd;
   logic                    transientEvent;
   tdtc_pkg::tdtc_tap_src_t tapEventSource;
   logic                    doubleTapSuspended;
   int                      nMismatch;
   int                      nCompared;
   int                      cycles;
   int                      n;
   logic [7:0]              d;
   logic [2:0]              ax;

   tdtc_top #(.STEP_BASE_CYC(BASE)) tdtc_top_i (.sys_clk(sys_clk), .nrst(nrst), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .outputSampleRate(outputSampleRate), .sampleMode(sampleMode), .joltExceed(joltExceed),
      .debounceCounterMode(debounceCounterMode), .tapHit(tapHit), .latencyOpen(latencyOpen),
      .pulseStart(pulseStart), .pulseEnd(pulseEnd), .transientEvent(transientEvent),
      .tapEventSource(tapEventSource), .doubleTapSuspended(doubleTapSuspended));
   tdtc_host_model tdtc_host_model_i (.sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

   always #12.5 sys_clk = ~sys_clk;

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles > 60000)
      begin
         nMismatch++;
         print_verdict();
      end
   end

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      nCompared++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      cmp8({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic cmp_int(input int got, input int exp, input string what);
      nCompared++;
      if (got != exp)
      begin
         nMismatch++;
         $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // cycles from driving the jolt level until the event follows it
   task automatic measure(input logic v, output int cnt);
      @(posedge sys_clk);
      joltExceed <= v;
      cnt = 1;
      do
      begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
      while (transientEvent !== v && cnt < 3000);
   endtask

   task automatic tap(input logic [8:0] h);
      @(posedge sys_clk);
      tapHit <= h;
      @(posedge sys_clk);
      tapHit <= '0;
      #1;
   endtask

   task automatic pls(input logic lo, input logic s, input logic e);
      @(posedge sys_clk);
      latencyOpen <= lo;
      pulseStart  <= s;
      pulseEnd    <= e;
      @(posedge sys_clk);
      pulseStart <= 1'b0;
      pulseEnd   <= 1'b0;
      #1;
   endtask

   initial
   begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      outputSampleRate = tdtc_pkg::TDTC_RATE_800;
      sampleMode = tdtc_pkg::TDTC_MODE_NORMAL;
      joltExceed = 1'b0;
      debounceCounterMode = 1'b0;
      tapHit = '0;
      latencyOpen = 1'b0;
      pulseStart = 1'b0;
      pulseEnd = 1'b0;
      nMismatch = 0;
      nCompared = 0;
      cycles = 0;
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (ROWS[i])
      begin
         if (i < 4)
         begin
            tdtc_host_model_i.rd(8'h20 + i[7:0] * 8'h10 / 8'h08, d);
            cmp8(d, 8'h00, "reset read");
         end
      end
      tdtc_host_model_i.wr(8'h22, 8'hff);
      tdtc_host_model_i.rd(8'h22, d);
      cmp8(d, 8'h00, "source read only");
      tdtc_host_model_i.wr(8'h21, 8'h3c);
      tdtc_host_model_i.rd(8'h21, d);
      cmp8(d, 8'h3c, "config readback");
      foreach (ROWS[i])
      begin
         @(posedge sys_clk);
         outputSampleRate <= tdtc_pkg::tdtc_rate_t'(ROWS[i].rate);
         sampleMode <= tdtc_pkg::tdtc_mode_t'(ROWS[i].mode);
         measure(1'b1, n);
         measure(1'b0, n);
         measure(1'b1, n);
         cmp_int(n, int'(ROWS[i].mult) * BASE, "step to rise");
         measure(1'b0, n);
         cmp_int(n, int'(ROWS[i].mult) * BASE, "step to fall");
      end
      tdtc_host_model_i.wr(8'h20, 8'h03);
      @(posedge sys_clk);
      outputSampleRate <= tdtc_pkg::TDTC_RATE_800;
      sampleMode <= tdtc_pkg::TDTC_MODE_NORMAL;
      measure(1'b1, n);
      measure(1'b0, n);
      cmp_int(n, BASE, "fall");
      measure(1'b1, n);
      cmp_int(n, 2 * BASE, "after decrement");
      @(posedge sys_clk);
      debounceCounterMode <= 1'b1;
      measure(1'b0, n);
      measure(1'b1, n);
      cmp_int(n, 4 * BASE, "after clear");
      // enable bits by kind and axis
      for (int i = 0; i < 6; i++)
      begin
         tdtc_host_model_i.wr(8'h21, 8'h01 << i);
         ax = 3'b001 << (i / 2);
         tap(9'b111_000_000);
         cmp8(tapEventSource, i[0] ? 8'h00 : {1'b1, ax, 4'h0}, "single enable");
         tap(9'b000_111_000);
         cmp8(tapEventSource, i[0] ? {1'b1, ax, 4'h8} : 8'h00, "double enable");
      end
      tdtc_host_model_i.wr(8'h21, 8'h41);
      tap(9'b001_000_001);
      cmp8(tapEventSource, 8'h91, "latched");
      tap(9'b001_000_000);
      cmp8(tapEventSource, 8'h91, "held");
      tdtc_host_model_i.rd(8'h22, d);
      cmp8(d, 8'h91, "source read");
      cmp8(tapEventSource, 8'h00, "read clears");
      tdtc_host_model_i.wr(8'h21, 8'h01);
      tap(9'b001_000_001);
      cmp8(tapEventSource, 8'h91, "live shows hit");
      @(posedge sys_clk);
      #1;
      cmp8(tapEventSource, 8'h00, "live follows");
      tdtc_host_model_i.wr(8'h21, 8'h82);
      pls(1'b1, 1'b0, 1'b0);
      pls(1'b1, 1'b1, 1'b0);
      pls(1'b1, 1'b0, 1'b1);
      cmp_bit(doubleTapSuspended, 1'b1, "suspend");
      tap(9'b000_001_000);
      cmp8(tapEventSource, 8'h00, "suspended double");
      pls(1'b0, 1'b1, 1'b0);
      cmp_bit(doubleTapSuspended, 1'b0, "resume");
      tdtc_host_model_i.wr(8'h21, 8'h02);
      pls(1'b1, 1'b1, 1'b0);
      pls(1'b1, 1'b0, 1'b1);
      cmp_bit(doubleTapSuspended, 1'b0, "no abort");
      tap(9'b000_001_000);
      cmp8(tapEventSource, 8'h98, "double kept");
      // mid-run reset
      @(posedge sys_clk);
      nrst <= 1'b0;
      @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      cmp_bit(transientEvent, 1'b0, "event reset");
      tdtc_host_model_i.rd(8'h20, d);
      cmp8(d, 8'h00, "count reset");
      print_verdict();
   end
endmodule // test_transient_debounce_tap_config

//--- hdl/tdtc_step_timer.sv
// Purpose: debounce time-step generator chosen by sample rate and oversampling mode
// Assumes: rate and mode are quasi-static register fields
// Notes:   a change of setting applies to the running step one cycle later; the timer is not restarted
`timescale 1ns/1ps
module tdtc_step_timer
#(
   parameter int unsigned STEP_BASE_CYC = tdtc_pkg::TDTC_STEP_BASE_CYC
)
(
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   input  wire tdtc_pkg::tdtc_rate_t outputSampleRate,
   input  wire tdtc_pkg::tdtc_mode_t sampleMode,
   output logic                      stepTick
);

   logic [7:0]                          mult;
   logic [tdtc_pkg::TDTC_TMR_W-1:0]     stepPeriod;
   logic [tdtc_pkg::TDTC_TMR_W-1:0]     tmr;

   always_comb
   begin
      mult = tdtc_pkg::TDTC_MUL_20;
      unique case (outputSampleRate)
         tdtc_pkg::TDTC_RATE_800 : mult = tdtc_pkg::TDTC_MUL_1P25;
         tdtc_pkg::TDTC_RATE_400 : mult = tdtc_pkg::TDTC_MUL_2P5;
         tdtc_pkg::TDTC_RATE_200 : mult = tdtc_pkg::TDTC_MUL_5;
         tdtc_pkg::TDTC_RATE_100 : mult = tdtc_pkg::TDTC_MUL_10;
         tdtc_pkg::TDTC_RATE_50  : mult = tdtc_pkg::TDTC_MUL_20;
         tdtc_pkg::TDTC_RATE_12P5: mult = (sampleMode == tdtc_pkg::TDTC_MODE_NORMAL) ?
                                          tdtc_pkg::TDTC_MUL_20 : tdtc_pkg::TDTC_MUL_80;
         tdtc_pkg::TDTC_RATE_6P25,
         tdtc_pkg::TDTC_RATE_1P56:
         begin
            if (sampleMode == tdtc_pkg::TDTC_MODE_NORMAL)
               mult = tdtc_pkg::TDTC_MUL_20;
            else if (sampleMode == tdtc_pkg::TDTC_MODE_LOWPWR)
               mult = tdtc_pkg::TDTC_MUL_160;
            else
               mult = tdtc_pkg::TDTC_MUL_80;
         end
      endcase
      // high resolution never exceeds 2.5 ms
      if (sampleMode == tdtc_pkg::TDTC_MODE_HIRES && outputSampleRate != tdtc_pkg::TDTC_RATE_800)
         mult = tdtc_pkg::TDTC_MUL_2P5;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         stepPeriod <= '0;
      else
         stepPeriod <= tdtc_pkg::TDTC_TMR_W'(32'(mult) * STEP_BASE_CYC);
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tmr      <= '0;
         stepTick <= 1'b0;
      end
      else if (stepPeriod != '0 && tmr >= stepPeriod - 1'b1)
      begin
         tmr      <= '0;
         stepTick <= 1'b1;
      end
      else
      begin
         tmr      <= tmr + 1'b1;
         stepTick <= 1'b0;
      end
   end

   // the period register only reloads one cycle after reset is released
   fast_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(nrst) && $past(outputSampleRate == tdtc_pkg::TDTC_RATE_800)
      |-> stepPeriod == tdtc_pkg::TDTC_TMR_W'(STEP_BASE_CYC))
      else $error("800 Hz step is not 1.25 ms");

   hires_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(nrst) && $past(sampleMode == tdtc_pkg::TDTC_MODE_HIRES && outputSampleRate != tdtc_pkg::TDTC_RATE_800)
      |-> stepPeriod == tdtc_pkg::TDTC_TMR_W'(2 * STEP_BASE_CYC))
      else $error("high resolution step is not 2.5 ms");

   slow_lp_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(nrst) && $past(sampleMode == tdtc_pkg::TDTC_MODE_LOWPWR && outputSampleRate >= tdtc_pkg::TDTC_RATE_6P25)
      |-> stepPeriod == tdtc_pkg::TDTC_TMR_W'(128 * STEP_BASE_CYC))
      else $error("slow low power step is not 160 ms");

endmodule // tdtc_step_timer

//--- hdl/tdtc_top.sv
// Purpose: jolt debounce counter and tap detect configuration with event source latching
// Assumes: register port strobes come from the serial host interface, one cycle each
// Notes:   jolt comparison and pulse timing are done upstream; this block qualifies them
`timescale 1ns/1ps
module tdtc_top
#(
   parameter int unsigned STEP_BASE_CYC = tdtc_pkg::TDTC_STEP_BASE_CYC
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   input  wire logic [7:0]             regAddr,
   input  wire logic [7:0]             regWdata,
   output logic [7:0]                  regRdata,
   input  wire tdtc_pkg::tdtc_rate_t   outputSampleRate,
   input  wire tdtc_pkg::tdtc_mode_t   sampleMode,
   input  wire logic                   joltExceed,
   input  wire logic                   debounceCounterMode,
   input  wire tdtc_pkg::tdtc_tap_hit_t tapHit,
   input  wire logic                   latencyOpen,
   input  wire logic                   pulseStart,
   input  wire logic                   pulseEnd,
   output logic                        transientEvent,
   output tdtc_pkg::tdtc_tap_src_t     tapEventSource,
   output logic                        doubleTapSuspended
);

   logic [7:0]                debounceCount;
   tdtc_pkg::tdtc_tap_cfg_t   tapCfg;
   logic [7:0]                debCnt;
   logic                      stepTick;
   logic                      inWindow;
   logic                      srcRead;
   logic [2:0]                singleEn;
   logic [2:0]                doubleEn;
   logic [2:0]                singleQual;
   logic [2:0]                doubleQual;
   logic                      tapAny;
   tdtc_pkg::tdtc_tap_src_t   next_tapSrc;

   tdtc_step_timer #(
      .STEP_BASE_CYC (STEP_BASE_CYC)
   ) u_step (
      .sys_clk          (sys_clk),
      .nrst             (nrst),
      .outputSampleRate (outputSampleRate),
      .sampleMode       (sampleMode),
      .stepTick         (stepTick)
   );

   assign srcRead = regRead && regAddr == tdtc_pkg::TDTC_OFS_TAP_SOURCE;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         debounceCount <= tdtc_pkg::TDTC_DEBOUNCE_COUNT_RST;
         tapCfg        <= tdtc_pkg::TDTC_TAP_CONFIG_RST;
      end
      else if (regWrite)
      begin
         if (regAddr == tdtc_pkg::TDTC_OFS_DEBOUNCE_COUNT)
            debounceCount <= regWdata;
         if (regAddr == tdtc_pkg::TDTC_OFS_TAP_CONFIG)
            tapCfg <= regWdata;
      end
   end

   // read data holds until the next read
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         regRdata <= tdtc_pkg::TDTC_UNMAPPED_READ;
      else if (regRead)
      begin
         unique case (regAddr)
            tdtc_pkg::TDTC_OFS_DEBOUNCE_COUNT: regRdata <= debounceCount;
            tdtc_pkg::TDTC_OFS_TAP_CONFIG    : regRdata <= tapCfg;
            tdtc_pkg::TDTC_OFS_TAP_SOURCE    : regRdata <= tapEventSource;
            default                          : regRdata <= tdtc_pkg::TDTC_UNMAPPED_READ;
         endcase
      end
   end

   // debounce counter stepped by the time base
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         debCnt         <= '0;
         transientEvent <= 1'b0;
      end
      else if (stepTick)
      begin
         if (joltExceed)
         begin
            if (debCnt >= debounceCount)
               transientEvent <= 1'b1;
            else
               debCnt <= debCnt + 1'b1;
         end
         else
         begin
            transientEvent <= 1'b0;
            if (debounceCounterMode)
               debCnt <= '0;
            else if (debCnt != '0)
               debCnt <= debCnt - 1'b1;
         end
      end
   end

   // per-axis enables, index 2 = z
   assign singleEn = {tapCfg.zSingleTapEnable, tapCfg.ySingleTapEnable, tapCfg.xSingleTapEnable};
   assign doubleEn = {tapCfg.zDoubleTapEnable, tapCfg.yDoubleTapEnable, tapCfg.xDoubleTapEnable};

   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++)
      begin : g_axis
         assign singleQual[ax] = tapHit.single[ax] && singleEn[ax];
         assign doubleQual[ax] = tapHit.double[ax] && doubleEn[ax] && !doubleTapSuspended;
      end
   endgenerate

   assign tapAny = |singleQual || |doubleQual;

   always_comb
   begin
      next_tapSrc        = '0;
      next_tapSrc.active = tapAny;
      next_tapSrc.axis   = singleQual | doubleQual;
      next_tapSrc.dbl    = |doubleQual;
      next_tapSrc.pol    = tapHit.pol & (singleQual | doubleQual);
   end

   // track a pulse that starts inside the latency window
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         inWindow <= 1'b0;
      else if (pulseStart)
         inWindow <= latencyOpen;
      else if (!latencyOpen)
         inWindow <= 1'b0;
   end

   // suspend only with abort set, until a new tap sequence starts
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         doubleTapSuspended <= 1'b0;
      else if (!tapCfg.doubleTapAbort)
         doubleTapSuspended <= 1'b0;
      else if (pulseEnd && latencyOpen && (inWindow || pulseStart))
         doubleTapSuspended <= 1'b1;
      else if (pulseStart && !latencyOpen)
         doubleTapSuspended <= 1'b0;
   end

   // source register, live or latched; a new event wins over the read clear
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         tapEventSource <= tdtc_pkg::TDTC_TAP_SOURCE_RST;
      else if (!tapCfg.eventLatchEnable)
         tapEventSource <= next_tapSrc;
      else if (tapAny && (!tapEventSource.active || srcRead))
         tapEventSource <= next_tapSrc;
      else if (srcRead)
         tapEventSource <= tdtc_pkg::TDTC_TAP_SOURCE_RST;
   end

   jolt_after_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(transientEvent) |-> $past(stepTick && joltExceed && debCnt >= debounceCount))
      else $error("jolt event raised before debounce count reached");

   count_on_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !stepTick |=> $stable(debCnt))
      else $error("debounce counter moved without a step");

   zero_count_fire_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      stepTick && joltExceed && debounceCount == 8'h00 |=> transientEvent)
      else $error("zero count did not flag on first exceeding sample");

   mode_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      stepTick && !joltExceed && debounceCounterMode |=> debCnt == 8'h00 && !transientEvent)
      else $error("clear mode did not clear the counter");

   mode_decrement_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      stepTick && !joltExceed && !debounceCounterMode && debCnt != 8'h00 |=> debCnt == $past(debCnt) - 8'h01)
      else $error("decrement mode did not decrement");

   no_abort_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !tapCfg.doubleTapAbort |=> !doubleTapSuspended)
      else $error("double tap suspended with abort clear");

   abort_suspend_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      tapCfg.doubleTapAbort && !regWrite && pulseEnd && latencyOpen && inWindow |=> doubleTapSuspended)
      else $error("pulse inside latency window did not suspend double tap");

   latched_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      tapCfg.eventLatchEnable && tapEventSource.active && !srcRead |=> $stable(tapEventSource))
      else $error("latched tap source changed without a read");

   read_clears_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      tapCfg.eventLatchEnable && srcRead && !tapAny |=> tapEventSource == 8'h00)
      else $error("tap source read did not clear latched flags");

   axis_enable_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(tapEventSource.axis[0]) |-> $past(tapCfg.xSingleTapEnable || tapCfg.xDoubleTapEnable))
      else $error("x tap flagged with both x enables clear");

endmodule // tdtc_top

//--- pkg/tdtc_pkg.sv
// Purpose: shared constants and types for the jolt debounce and tap configuration block
// Assumes: 40 MHz system clock, 8-bit register port behind the serial host interface
// Notes:   rate and mode codes follow the device's own sample-rate and oversampling encoding
package tdtc_pkg;

   // register map
   localparam logic [7:0] TDTC_OFS_DEBOUNCE_COUNT = 8'h20;
   localparam logic [7:0] TDTC_OFS_TAP_CONFIG     = 8'h21;
   localparam logic [7:0] TDTC_OFS_TAP_SOURCE     = 8'h22;

   // reset and read-back values
   localparam logic [7:0] TDTC_DEBOUNCE_COUNT_RST = 8'h00;
   localparam logic [7:0] TDTC_TAP_CONFIG_RST     = 8'h00;
   localparam logic [7:0] TDTC_TAP_SOURCE_RST     = 8'h00;
   localparam logic [7:0] TDTC_UNMAPPED_READ      = 8'h00;

   // timing: the smallest debounce step, every other step is a power-of-two multiple
   localparam int unsigned TDTC_CLK_PERIOD_NS = 25;
   localparam int unsigned TDTC_STEP_BASE_NS  = 1250000;
   localparam int unsigned TDTC_STEP_BASE_CYC = (TDTC_STEP_BASE_NS + TDTC_CLK_PERIOD_NS - 1) / TDTC_CLK_PERIOD_NS;
   localparam int unsigned TDTC_TMR_W         = 24;

   // step multipliers of the base step: 1.25, 2.5, 5, 10, 20, 80, 160 ms
   localparam logic [7:0] TDTC_MUL_1P25 = 8'h01;
   localparam logic [7:0] TDTC_MUL_2P5  = 8'h02;
   localparam logic [7:0] TDTC_MUL_5    = 8'h04;
   localparam logic [7:0] TDTC_MUL_10   = 8'h08;
   localparam logic [7:0] TDTC_MUL_20   = 8'h10;
   localparam logic [7:0] TDTC_MUL_80   = 8'h40;
   localparam logic [7:0] TDTC_MUL_160  = 8'h80;

   typedef enum logic [2:0] {
      TDTC_RATE_800  = 3'h0,
      TDTC_RATE_400  = 3'h1,
      TDTC_RATE_200  = 3'h2,
      TDTC_RATE_100  = 3'h3,
      TDTC_RATE_50   = 3'h4,
      TDTC_RATE_12P5 = 3'h5,
      TDTC_RATE_6P25 = 3'h6,
      TDTC_RATE_1P56 = 3'h7
   } tdtc_rate_t;

   typedef enum logic [1:0] {
      TDTC_MODE_NORMAL = 2'h0,
      TDTC_MODE_LNLP   = 2'h1,
      TDTC_MODE_HIRES  = 2'h2,
      TDTC_MODE_LOWPWR = 2'h3
   } tdtc_mode_t;

   // tap detect configuration register layout, bit 7 down to bit 0
   typedef struct packed {
      logic doubleTapAbort;
      logic eventLatchEnable;
      logic zDoubleTapEnable;
      logic zSingleTapEnable;
      logic yDoubleTapEnable;
      logic ySingleTapEnable;
      logic xDoubleTapEnable;
      logic xSingleTapEnable;
   } tdtc_tap_cfg_t;

   // tap event source layout: active, axis z/y/x, double, polarity z/y/x
   typedef struct packed {
      logic       active;
      logic [2:0] axis;
      logic       dbl;
      logic [2:0] pol;
   } tdtc_tap_src_t;

   // raw tap hits from the pulse detector, index 2 = z, 1 = y, 0 = x
   typedef struct packed {
      logic [2:0] single;
      logic [2:0] double;
      logic [2:0] pol;
   } tdtc_tap_hit_t;

endpackage
